// >>> logic/bcd_regs.vh
// Constants for the baud clock divider and I/O select decode.
// Assumes a 100 MHz reference clock and 2 MHz base clocks arriving on pins.
`ifndef BCD_REGS_VH
`define BCD_REGS_VH

// Reference clock period in ns
`define BCD_REF_PERIOD_NS 10
// Base clock frequency in kHz, the figure every rate is derived from
`define BCD_BASE_KHZ 2000
// Serial clock is sixteen times the bit rate
`define BCD_OVERSAMPLE 16

// Divider ratios of the counter stages
`define BCD_DIV_TOP 13
`define BCD_DIV_HALF 2
`define BCD_DIV_SLOW 11

// Rate select codes of the per-port switch
`define BCD_SEL_9600 3'h0
`define BCD_SEL_4800 3'h1
`define BCD_SEL_2400 3'h2
`define BCD_SEL_1200 3'h3
`define BCD_SEL_600 3'h4
`define BCD_SEL_300 3'h5
`define BCD_SEL_150 3'h6
`define BCD_SEL_110 3'h7
// Index of the 1200 stage in the halving chain, feeds the slow stage
`define BCD_IDX_1200 3

// Base clock source select codes
`define BCD_SRC_MASTER 1'b0
`define BCD_SRC_SERIAL 1'b1

// Low address nibble windows of the two I/O sections
`define BCD_PAR_LO 4'h8
`define BCD_PAR_HI 4'hB
`define BCD_SER_LO 4'h2
`define BCD_SER_HI 4'h3

// Longest gap between base clock edges before the base counts as stopped
`define BCD_BASE_TIMEOUT_NS 2000
`define BCD_BASE_TIMEOUT_CYC (`BCD_BASE_TIMEOUT_NS / `BCD_REF_PERIOD_NS)

// Reset values
`define BCD_RST_WAVE 1'b0
`define BCD_RST_SELECT 1'b0

`endif

// >>> logic/bcd_div_stage.v
// One counter stage of the divider chain: counts step pulses modulo DIV.
// Assumes step_i is a one-cycle pulse on ref_clk_i; gives a terminal count and a near-square wave.
`timescale 1ns/1ps
`include "bcd_regs.vh"
module bcd_div_stage #(
	parameter DIV = 13,
	parameter W = 4
) (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire step_i,
	output wire tc_o,
	output wire wave_o
);
	// Ratio figures are integers; cut them to the counter width on purpose
	localparam integer LAST_I = DIV - 1;
	localparam integer HALF_I = (DIV + 1) / 2;
	localparam [W-1:0] LAST = LAST_I[W-1:0];
	localparam [W-1:0] HALF = HALF_I[W-1:0];
	localparam [W-1:0] ZERO = 0;
	localparam [W-1:0] ONE = 1;

	reg [W-1:0] count_ff;
	reg [W-1:0] nxt_count;
	reg wave_ff;
	reg nxt_wave;

	// Terminal count is gated by the step so it lasts one reference cycle
	assign tc_o = step_i && (count_ff == LAST);
	assign wave_o = wave_ff;

	// Count and wave; odd ratios keep the high phase one step longer
	// Wave moves only on a step, so no output edge appears before the base runs
	always @* begin
		nxt_count = count_ff;
		nxt_wave = wave_ff;
		if (step_i) begin
			if (count_ff == LAST) begin
				nxt_count = ZERO;
			end else begin
				nxt_count = count_ff + ONE;
			end
			nxt_wave = (nxt_count < HALF);
		end
	end

	// Free running from reset, no software hold
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_ff <= ZERO;
			wave_ff <= `BCD_RST_WAVE;
		end else begin
			count_ff <= nxt_count;
			wave_ff <= nxt_wave;
		end
	end
endmodule // bcd_div_stage

// >>> logic/bcd_baud_clock.v
// Baud clock generator and I/O section select decode.
// Assumes base clocks, switches, address and memory request all come from pins,
// sampled on the 100 MHz reference clock; base clocks are far slower than it.
`timescale 1ns/1ps
`include "bcd_regs.vh"

module bcd_baud_clock #(
	parameter ADDR_W = 8,
	parameter [3:0] IO_PAGE = 4'h0
) (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire master_base_clock_i,
	input wire serial_base_clock_i,
	input wire base_src_i,
	input wire [2:0] rate_sel0_i,
	input wire [2:0] rate_sel1_i,
	input wire [ADDR_W-1:0] addr_i,
	input wire memory_request_n_i,
	output wire usart_transmit_clock0_o,
	output wire usart_receive_clock0_o,
	output wire usart_transmit_clock1_o,
	output wire usart_receive_clock1_o,
	output wire base_running_o,
	output wire serial_select_o,
	output wire parallel_select_o
);
	// Width of the pin group that passes the synchroniser
	localparam SYNC_W = 2 + 1 + 3 + 3 + ADDR_W + 1;
	// Number of halving stages below 9600
	localparam HALVES = 6;
	// Cycles allowed between base edges, rounded down, at least one
	localparam integer TIMEOUT_I = (`BCD_BASE_TIMEOUT_CYC < 1) ? 1 : `BCD_BASE_TIMEOUT_CYC;
	localparam [7:0] TIMEOUT_CYC = TIMEOUT_I[7:0];
	// Page number widened to the upper address field without a zero-width replication
	localparam integer PAGE_I = IO_PAGE;
	localparam [ADDR_W-5:0] PAGE_ID = PAGE_I[ADDR_W-5:0];
	localparam [7:0] CNT_ZERO = 8'h00;
	localparam [7:0] CNT_ONE = 8'h01;

	// Pick one rate wave by switch code
	function pick_rate;
		input [7:0] waves;
		input [2:0] sel;
		begin
			pick_rate = waves[sel];
		end
	endfunction

	// True when the address lies in a window of the I/O page
	function addr_hit;
		input [ADDR_W-1:0] addr;
		input [3:0] lo;
		input [3:0] hi;
		begin
			addr_hit = (addr[ADDR_W-1:4] == PAGE_ID) && (addr[3:0] >= lo) && (addr[3:0] <= hi);
		end
	endfunction

	wire [SYNC_W-1:0] pins_raw;
	reg [SYNC_W-1:0] meta_ff;
	reg [SYNC_W-1:0] sync_ff;
	wire master_s;
	wire serial_s;
	wire src_s;
	wire [2:0] sel0_s;
	wire [2:0] sel1_s;
	wire [ADDR_W-1:0] addr_s;
	wire memory_request_n_s;

	reg base_prev_ff;
	wire base_level;
	wire base_step;
	reg [7:0] idle_cnt_ff;
	reg [7:0] nxt_idle_cnt;
	reg running_ff;
	reg nxt_running;

	wire [HALVES:0] ticks;
	wire [7:0] waves;

	reg tx0_ff;
	reg tx1_ff;
	reg ser_sel_ff;
	reg par_sel_ff;
	reg nxt_ser_sel;
	reg nxt_par_sel;

	// All pins share one two-stage synchroniser
	assign pins_raw = {master_base_clock_i, serial_base_clock_i, base_src_i, rate_sel0_i, rate_sel1_i,
		addr_i, memory_request_n_i};

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_ff <= {SYNC_W{1'b0}};
			sync_ff <= {SYNC_W{1'b0}};
		end else begin
			meta_ff <= pins_raw;
			sync_ff <= meta_ff;
		end
	end

	// Unpack the synchronised pins; only the second stage is read
	assign master_s = sync_ff[SYNC_W-1];
	assign serial_s = sync_ff[SYNC_W-2];
	assign src_s = sync_ff[SYNC_W-3];
	assign sel0_s = sync_ff[SYNC_W-4:SYNC_W-6];
	assign sel1_s = sync_ff[SYNC_W-7:SYNC_W-9];
	assign addr_s = sync_ff[ADDR_W:1];
	assign memory_request_n_s = sync_ff[0];

	// Base source: board master clock or dedicated serial clock
	assign base_level = (src_s == `BCD_SRC_SERIAL) ? serial_s : master_s;

	// Rising base edge becomes a one-cycle step; a source swap may add one stray step
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			base_prev_ff <= 1'b0;
		end else begin
			base_prev_ff <= base_level;
		end
	end
	assign base_step = base_level && !base_prev_ff;

	// Watch for a stopped base clock so the rate outputs can be trusted
	always @* begin
		nxt_idle_cnt = idle_cnt_ff;
		nxt_running = running_ff;
		if (base_step) begin
			nxt_idle_cnt = CNT_ZERO;
			nxt_running = 1'b1;
		end else if (idle_cnt_ff >= TIMEOUT_CYC) begin
			nxt_running = 1'b0;
		end else begin
			nxt_idle_cnt = idle_cnt_ff + CNT_ONE;
		end
	end

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idle_cnt_ff <= CNT_ZERO;
			running_ff <= 1'b0;
		end else begin
			idle_cnt_ff <= nxt_idle_cnt;
			running_ff <= nxt_running;
		end
	end
	assign base_running_o = running_ff;

	// Top stage: 2 MHz over 13 is about 153.8 kHz, sixteen times 9600
	bcd_div_stage #(
		.DIV(`BCD_DIV_TOP),
		.W(4)
	) u_top (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.step_i(base_step),
		.tc_o(ticks[0]),
		.wave_o(waves[`BCD_SEL_9600])
	);

	// Halving chain 4800 down to 150, each fed by the terminal count above
	genvar gi;
	generate
		for (gi = 1; gi <= HALVES; gi = gi + 1) begin : g_half
			bcd_div_stage #(
				.DIV(`BCD_DIV_HALF),
				.W(1)
			) u_half (
				.ref_clk_i(ref_clk_i),
				.rst_n_i(rst_n_i),
				.step_i(ticks[gi-1]),
				.tc_o(ticks[gi]),
				.wave_o(waves[gi])
			);
		end
	endgenerate

	// The 110 rate hangs off the 1200 terminal count, not off 150
	bcd_div_stage #(
		.DIV(`BCD_DIV_SLOW),
		.W(4)
	) u_slow (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.step_i(ticks[`BCD_IDX_1200]),
		.tc_o(),
		.wave_o(waves[`BCD_SEL_110])
	);

	// Switch picks one rate per port; both USART clock pins share it
	// Counters carry no enable, so the clocks run whenever the base runs
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx0_ff <= `BCD_RST_WAVE;
			tx1_ff <= `BCD_RST_WAVE;
		end else begin
			tx0_ff <= pick_rate(waves, sel0_s);
			tx1_ff <= pick_rate(waves, sel1_s);
		end
	end
	assign usart_transmit_clock0_o = tx0_ff;
	assign usart_receive_clock0_o = tx0_ff;
	assign usart_transmit_clock1_o = tx1_ff;
	assign usart_receive_clock1_o = tx1_ff;

	// Selects only outside memory cycles, so a memory address never hits the I/O parts
	always @* begin
		nxt_ser_sel = memory_request_n_s && addr_hit(addr_s, `BCD_SER_LO, `BCD_SER_HI);
		nxt_par_sel = memory_request_n_s && addr_hit(addr_s, `BCD_PAR_LO, `BCD_PAR_HI);
	end

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ser_sel_ff <= `BCD_RST_SELECT;
			par_sel_ff <= `BCD_RST_SELECT;
		end else begin
			ser_sel_ff <= nxt_ser_sel;
			par_sel_ff <= nxt_par_sel;
		end
	end
	assign serial_select_o = ser_sel_ff;
	assign parallel_select_o = par_sel_ff;
endmodule // bcd_baud_clock

// >>> test/bcd_baud_checker.sv
// Port checker for the baud clock divider and its I/O select decode.
// Assumes binding to bcd_baud_clock; decode checks wait out the sync delay.
`timescale 1ns/1ps
module bcd_baud_checker #(
	parameter ADDR_W = 8,
	parameter [3:0] IO_PAGE = 4'h0
) (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire master_base_clock_i,
	input wire serial_base_clock_i,
	input wire base_src_i,
	input wire [2:0] rate_sel0_i,
	input wire [2:0] rate_sel1_i,
	input wire [ADDR_W-1:0] addr_i,
	input wire memory_request_n_i,
	input wire usart_transmit_clock0_o,
	input wire usart_receive_clock0_o,
	input wire usart_transmit_clock1_o,
	input wire usart_receive_clock1_o,
	input wire serial_select_o,
	input wire parallel_select_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Decode targets, held four samples so the sync stages have settled
	wire ser_hit = memory_request_n_i && addr_i[7:4] == IO_PAGE && addr_i[3:0] >= 4'h2 && addr_i[3:0] <= 4'h3;
	wire par_hit = memory_request_n_i && addr_i[7:4] == IO_PAGE && addr_i[3:0] >= 4'h8 && addr_i[3:0] <= 4'hB;
	wire base_w = base_src_i ? serial_base_clock_i : master_base_clock_i;
	reg base_ff;
	reg [7:0] rise_ff;
	reg [5:0] sel_prev_ff;
	reg [7:0] sel_chg_ff;
	// Recent base rises or switch moves; a rate clock may only move after one
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			base_ff <= 1'b0;
			rise_ff <= 8'h00;
			sel_prev_ff <= 6'h00;
			sel_chg_ff <= 8'h00;
		end else begin
			base_ff <= base_w;
			rise_ff <= {rise_ff[6:0], base_w & ~base_ff};
			sel_prev_ff <= {rate_sel0_i, rate_sel1_i};
			sel_chg_ff <= {sel_chg_ff[6:0], {rate_sel0_i, rate_sel1_i} != sel_prev_ff};
		end
	end
	sequence ser_held; ser_hit[*4]; endsequence
	sequence par_held; par_hit[*4]; endsequence
	port0_pair_a: assert property (usart_transmit_clock0_o == usart_receive_clock0_o) else $error("port0 clocks split");
	port1_pair_a: assert property (usart_transmit_clock1_o == usart_receive_clock1_o) else $error("port1 clocks split");
	ser_on_a: assert property (ser_held |-> serial_select_o) else $error("serial select missing");
	ser_off_a: assert property ((!ser_hit)[*4] |-> !serial_select_o) else $error("serial select stray");
	par_on_a: assert property (par_held |-> parallel_select_o) else $error("parallel select missing");
	par_off_a: assert property ((!par_hit)[*4] |-> !parallel_select_o) else $error("parallel select stray");
	memory_request_block_a: assert property ((!memory_request_n_i)[*4] |-> !serial_select_o && !parallel_select_o)
		else $error("select during memory request");
	rate_cause_a: assert property ($changed(usart_transmit_clock0_o) || $changed(usart_transmit_clock1_o) |-> |rise_ff || |sel_chg_ff)
		else $error("rate clock moved without base edge");
endmodule // bcd_baud_checker
bind bcd_baud_clock bcd_baud_checker #(.ADDR_W(ADDR_W), .IO_PAGE(IO_PAGE)) bcd_baud_checker_inst (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .master_base_clock_i(master_base_clock_i),
	.serial_base_clock_i(serial_base_clock_i), .base_src_i(base_src_i), .rate_sel0_i(rate_sel0_i),
	.rate_sel1_i(rate_sel1_i), .addr_i(addr_i),
	.memory_request_n_i(memory_request_n_i), .usart_transmit_clock0_o(usart_transmit_clock0_o),
	.usart_receive_clock0_o(usart_receive_clock0_o), .usart_transmit_clock1_o(usart_transmit_clock1_o),
	.usart_receive_clock1_o(usart_receive_clock1_o), .serial_select_o(serial_select_o),
	.parallel_select_o(parallel_select_o));

// >>> test/bcd_clk_model.sv
// Model of one USART clock input pair: times its high and low phases.
// Assumes the transmit and receive clocks of one port; counts reference cycles.
`timescale 1ns/1ps
module bcd_clk_model (
	input wire ref_clk_i,
	input wire txc_i,
	input wire rxc_i,
	output int hi_o,
	output int lo_o,
	output logic split_o
);
	int run;
	logic prev;
	initial begin
		hi_o = 0;
		lo_o = 0;
		split_o = 1'b0;
		run = 0;
		prev = 1'b0;
	end
	// Phase length is latched as the clock turns; the first one is partial
	always @(posedge ref_clk_i) begin
		if (txc_i !== rxc_i) split_o <= 1'b1;
		if (txc_i !== prev) begin
			if (prev) hi_o <= run;
			else lo_o <= run;
			run <= 1;
		end else run <= run + 1;
		prev <= txc_i;
	end
endmodule // bcd_clk_model

// >>> test/tb_top.sv
// Testbench for the baud clock divider: rate periods, base source, idle and decode.
// Assumes the design defaults ADDR_W 8 and IO_PAGE 0; base pins are driven here.
`timescale 1ns/1ps
module tb_top;
	logic ref_clk_i = 1'b0, rst_n_i = 1'b0, mclk = 1'b0, sclk = 1'b0, src = 1'b0, memory_request_n = 1'b1, sp0, sp1;
	logic [2:0] sel0 = 3'h0, sel1 = 3'h7;
	logic [7:0] addr = 8'h00;
	wire tx0, rx0, tx1, rx1, run_o, ser_o, par_o;
	int hp_m = 25, hp_s = 0, cm = 0, cs = 0, err_count = 0, checked = 0, h0, l0, h1, l1, half;
	initial forever #5 ref_clk_i = ~ref_clk_i;
	bcd_baud_clock bcd_baud_clock_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .master_base_clock_i(mclk),
		.serial_base_clock_i(sclk), .base_src_i(src), .rate_sel0_i(sel0), .rate_sel1_i(sel1), .addr_i(addr),
		.memory_request_n_i(memory_request_n), .usart_transmit_clock0_o(tx0), .usart_receive_clock0_o(rx0),
		.usart_transmit_clock1_o(tx1), .usart_receive_clock1_o(rx1), .base_running_o(run_o),
		.serial_select_o(ser_o), .parallel_select_o(par_o));
	bcd_clk_model bcd_clk_model_inst (.ref_clk_i(ref_clk_i), .txc_i(tx0), .rxc_i(rx0), .hi_o(h0), .lo_o(l0), .split_o(sp0));
	bcd_clk_model bcd_clk_model_inst_b (.ref_clk_i(ref_clk_i), .txc_i(tx1), .rxc_i(rx1), .hi_o(h1), .lo_o(l1), .split_o(sp1));
	// Base pins toggle on falling edges; a half period of 0 holds a pin still
	always @(negedge ref_clk_i) begin
		if (hp_m != 0) begin
			cm = cm + 1;
			if (cm >= hp_m) begin
				mclk = ~mclk;
				cm = 0;
			end
		end
		if (hp_s != 0) begin
			cs = cs + 1;
			if (cs >= hp_s) begin
				sclk = ~sclk;
				cs = 0;
			end
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen %0d expected %0d", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	task test_done;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// 2 MHz master base, 9600 tap: 7 base periods high, 6 low
	task t_base;
		cyc(2000);
		chk(h0, 7 * 50);
		chk(l0, 6 * 50);
		chk(run_o, 1'b1);
		$display("t_base done");
	endtask
	// Faster base for the slow taps; port 1 sits on 110 throughout
	task t_halving;
		hp_m = 5;
		for (int k = 1; k < 7; k++) begin
			sel0 = k[2:0];
			half = 13 * (1 << (k - 1)) * 10;
			cyc(6 * half + 50);
			chk(h0, half);
			chk(l0, half);
		end
		chk(h1, 6 * 104 * 10);
		chk(l1, 5 * 104 * 10);
		chk({sp0, sp1}, 2'b00);
		$display("t_halving done");
	endtask
	// Serial base at a distinct rate while the master pin stands still
	task t_src;
		src = 1'b1;
		hp_s = 6;
		hp_m = 0;
		sel0 = 3'h0;
		cyc(3 * 156 + 50);
		chk(h0, 7 * 12);
		chk(l0, 6 * 12);
		hp_s = 0;
		cyc(260);
		chk(run_o, 1'b0);
		hp_s = 6;
		cyc(50);
		chk(run_o, 1'b1);
		$display("t_src done");
	endtask
	// Every low nibble of the page, a foreign page, then a memory request
	task t_decode;
		for (int i = 0; i < 16; i++) begin
			addr = {4'h0, i[3:0]};
			cyc(4);
			chk(ser_o, i >= 2 && i <= 3);
			chk(par_o, i >= 8 && i <= 11);
		end
		addr = 8'h19;
		cyc(4);
		chk(par_o, 1'b0);
		addr = 8'h02;
		memory_request_n = 1'b0;
		cyc(4);
		chk({ser_o, par_o}, 2'b00);
		$display("t_decode done");
	endtask
	initial begin
		cyc(2);
		rst_n_i = 1'b1;
		cyc(1);
		chk({tx0, tx1, ser_o, par_o}, 4'h0);
		t_base;
		t_halving;
		t_src;
		t_decode;
		test_done;
	end
	// Watchdog sized above the sum of the scenario waits, about 52,400 cycles
	initial begin
		#700000;
		err_count++;
		test_done;
	end
endmodule // tb_top
